// ---- rtl/apg_map_gantry.sv ----
// apg_map_gantry: plane-to-axis routing, gantry link and register file
// assumes plane command sources and drive channels on ref_clk, markers async
//
// Overview of operation
// - the active plane command inputs are served one per cycle, round robin.
// - an axis mapped to plane zero never receives a motion command.
// - axis takes commands of its mapped plane whose designator matches its own.
// - after reset axes one to four sit in plane 1 as X, Y, Z, U.
// - axis n always drives channel n whatever its plane.
// - a slave mapped into a plane 1 to 4 other than its master's raises feedback error.
// - each command reaching a master is copied to its slave.
// - master byte names its slave; the invert bit reverses slave direction.
// - after reset no axis is a gantry master.
// - enabling a master also enables its slave.
// - a pair stays linked except while it runs its home cycle.
// - each axis of the pair searches its marker; the first one waits.
// - home done is flagged only after both axes finished their move.
// - home move is null distance plus home offset at the home feedrate.
// - active planes are 1, 2 or 4; buffer divides equally among them.
`timescale 1ns/10ps
module apg_map_gantry (
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   input  wire logic                    ce,
   input  wire apg_pkg::apg_avs_req_t   avs_req,
   output logic [31:0]                  avs_readdata,
   output logic                         avs_waitrequest,
   input  wire apg_pkg::apg_pcmd_t [3:0] pl_cmd,
   output logic [3:0]                   pl_ready,
   output apg_pkg::apg_acmd_t [3:0]     axis_cmd,
   output logic [3:0]                   drv_en,
   input  wire logic [3:0]              marker_pin,
   input  wire logic [3:0]              mv_done,
   input  wire apg_pkg::apg_step_t [3:0] null_dist,
   output logic [3:0]                   home_search,
   output logic [3:0]                   home_go,
   output apg_pkg::apg_step_t [3:0]     home_tgt,
   output logic [3:0][7:0]              home_feed,
   output logic                         home_busy,
   output logic                         home_done
);
   import apg_pkg::*;

   logic [31:0]       map_r, gan_r, ctl_r, hofs_a_r, hofs_b_r, hfeed_r;
   logic [31:0]       act_map_r, act_gan_r, rdata_r;
   logic [2:0]        act_npl_r;
   logic              ack_r, init_r, hstart_r, hdone_r, fb_err_r, role_err_r;
   logic [1:0]        slot_r, hm_r, hs_r;
   logic [3:0]        mk_s1_r, mk_s2_r, drv_en_r;
   apg_acmd_t [3:0]   ax_cmd_r;

   logic [3:0]        mst_v, inv, blocked, hit, linked, go_ax, drv_en_nxt;
   logic [3:0][1:0]   mst_i;
   logic              fb_err_c, role_err_c;
   logic              srch_m, srch_s, hgo, hpair_done;
   apg_step_t         tgt_m, tgt_s;
   apg_step_t [3:0]   hofs_w;

   // ---------------- Avalon-MM slave: one wait state on every access
   wire logic         req      = avs_req.read | avs_req.write;
   wire logic         take     = req & ack_r & ce;
   wire logic         wr_go    = take & avs_req.write;
   wire logic [31:0]  wd       = avs_req.writedata;
   wire logic [3:0]   be       = avs_req.byteenable;
   wire logic         sel_map  = avs_req.address == OFS_MAP;
   wire logic         sel_gan  = avs_req.address == OFS_GANTRY;
   wire logic         sel_ctl  = avs_req.address == OFS_CTRL;
   wire logic         sel_sts  = avs_req.address == OFS_STATUS;
   wire logic         sel_hoa  = avs_req.address == OFS_HOFS_A;
   wire logic         sel_hob  = avs_req.address == OFS_HOFS_B;
   wire logic         sel_hfd  = avs_req.address == OFS_HFEED;
   wire logic         sel_act  = avs_req.address == OFS_ACTMAP;
   wire logic [31:0]  ctl_wr   = apg_merge(ctl_r, wd, be);
   // init and home are actions, not stored bits
   wire logic [31:0]  ctl_keep = ctl_wr & ~(32'h1 << CTL_INIT) & ~(32'h1 << CTL_HOME);
   wire logic         init_go  = wr_go & sel_ctl & be[0] & wd[CTL_INIT];
   wire logic         home_req = wr_go & sel_ctl & be[0] & wd[CTL_HOME];
   wire logic [1:0]   hax      = wd[CTL_HAX_LSB +: 2];
   wire logic [3:0]   en_sw    = ctl_r[CTL_EN_LSB +: 4];
   wire logic [2:0]   npl_req  = ctl_r[CTL_NPL_LSB +: 3];

   assign avs_waitrequest = req & ~(ack_r & ce);
   assign avs_readdata    = rdata_r;

   // ---------------- plane count and buffer share
   wire logic [2:0]   npl_ok   = (npl_req == 3'h2 || npl_req == 3'h4) ? npl_req : NPL_RST;
   wire logic [1:0]   npl_m1   = 2'(act_npl_r - 3'h1);
   wire logic [1:0]   buf_sh   = act_npl_r == 3'h4 ? 2'h2 : act_npl_r == 3'h2 ? 2'h1 : 2'h0;
   wire logic [13:0]  buf_sz   = 14'(BUF_BYTES >> buf_sh);
   wire logic [1:0]   slot_nxt = 2'(slot_r + 2'h1) & npl_m1;

   wire logic [31:0]  status_w = {2'b00, buf_sz, 4'h0, blocked, drv_en_r,
                                  hdone_r, home_busy, role_err_r, fb_err_r};
   wire logic [31:0]  rd_mux   = sel_map ? map_r     :
                                 sel_gan ? gan_r     :
                                 sel_ctl ? ctl_r     :
                                 sel_sts ? status_w  :
                                 sel_hoa ? hofs_a_r  :
                                 sel_hob ? hofs_b_r  :
                                 sel_hfd ? hfeed_r   :
                                 sel_act ? act_map_r : 32'h0000_0000;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_r   <= 1'b0;
         rdata_r <= 32'h0000_0000;
      end else if (ce) begin
         ack_r <= req & ~ack_r;
         if (req && !ack_r) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // register writes; map, gantry and plane count are shadows whose live copies follow only on init
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         map_r    <= MAP_RST;
         gan_r    <= GAN_RST;
         ctl_r    <= CTL_RST;
         hofs_a_r <= HOFS_RST;
         hofs_b_r <= HOFS_RST;
         hfeed_r  <= HFEED_RST;
      end else if (wr_go) begin
         if (sel_map) map_r <= apg_merge(map_r, wd, be);
         if (sel_gan) gan_r <= apg_merge(gan_r, wd, be);
         if (sel_ctl) ctl_r <= ctl_keep;
         if (sel_hoa) hofs_a_r <= apg_merge(hofs_a_r, wd, be);
         if (sel_hob) hofs_b_r <= apg_merge(hofs_b_r, wd, be);
         if (sel_hfd) hfeed_r <= apg_merge(hfeed_r, wd, be);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         init_r    <= 1'b0;
         act_map_r <= MAP_RST;
         act_gan_r <= GAN_RST;
         act_npl_r <= NPL_RST;
      end else if (ce) begin
         init_r <= init_go;
         if (init_r) begin
            act_map_r <= map_r;
            act_gan_r <= gan_r;
            act_npl_r <= npl_ok;
         end
      end
   end

   // ---------------- configuration decode and error flags
   apg_cfg_chk u_chk (
      .map_w    (act_map_r),
      .gan_w    (act_gan_r),
      .mst_v    (mst_v),
      .mst_i    (mst_i),
      .inv      (inv),
      .blocked  (blocked),
      .fb_err   (fb_err_c),
      .role_err (role_err_c)
   );

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         fb_err_r   <= 1'b0;
         role_err_r <= 1'b0;
      end else if (ce) begin
         fb_err_r   <= fb_err_c;
         role_err_r <= role_err_c;
      end
   end

   // ---------------- plane multiplexing and axis routing
   wire apg_pcmd_t    cur      = pl_cmd[slot_r];
   wire logic         acc      = cur.valid & ce;
   wire logic [2:0]   cur_pl   = {1'b0, slot_r} + 3'h1;

   for (genvar a = 0; a < NAX; a++) begin : g_ax
      assign pl_ready[a] = ce & (slot_r == 2'(a));
      assign hit[a]      = acc && apg_plane(act_map_r, a) == cur_pl &&
                           apg_desf(act_map_r, a) == cur.des;
      // only the pair being homed drops its link
      assign linked[a]   = mst_v[a] & ~(home_busy & hs_r == 2'(a));
      assign go_ax[a]    = ~blocked[a] & (linked[a] ? hit[mst_i[a]] : hit[a]);
      assign drv_en_nxt[a] = en_sw[a] | (mst_v[a] & en_sw[mst_i[a]]);
      assign home_feed[a]  = hfeed_r[8*a +: 8];
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         slot_r   <= 2'h0;
         ax_cmd_r <= '0;
         drv_en_r <= 4'h0;
      end else if (ce) begin
         slot_r   <= init_r ? 2'h0 : slot_nxt;
         drv_en_r <= drv_en_nxt;
         for (int a = 0; a < NAX; a++) begin
            ax_cmd_r[a].valid <= go_ax[a];
            ax_cmd_r[a].step  <= (linked[a] && inv[a]) ? apg_step_t'(-cur.step)
                                                       : cur.step;
         end
      end
   end

   assign axis_cmd = ax_cmd_r;
   assign drv_en   = drv_en_r;

   // ---------------- gantry homing
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         mk_s1_r <= 4'h0;
         mk_s2_r <= 4'h0;
      end else if (ce) begin
         mk_s1_r <= marker_pin;
         mk_s2_r <= mk_s1_r;
      end
   end

   wire logic hstart_ok = home_req & ~home_busy & ~hstart_r &
                          act_gan_r[8*hax+GAN_YES] & ~role_err_r;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         hstart_r <= 1'b0;
         hm_r     <= 2'h0;
         hs_r     <= 2'h0;
         hdone_r  <= 1'b0;
      end else if (ce) begin
         hstart_r <= hstart_ok;
         if (hstart_ok) begin
            hm_r <= hax;
            hs_r <= apg_gslv(act_gan_r, int'(hax));
         end
         // completion wins over the clear of a new start
         if (hpair_done) begin
            hdone_r <= 1'b1;
         end else if (hstart_r) begin
            hdone_r <= 1'b0;
         end
      end
   end

   assign hofs_w = {hofs_b_r, hofs_a_r};

   apg_home_pair u_home (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .ce      (ce),
      .start   (hstart_r),
      .mk_m    (mk_s2_r[hm_r]),
      .mk_s    (mk_s2_r[hs_r]),
      .dn_m    (mv_done[hm_r]),
      .dn_s    (mv_done[hs_r]),
      .dist_m  (null_dist[hm_r]),
      .dist_s  (null_dist[hs_r]),
      .ofs_m   (hofs_w[hm_r]),
      .ofs_s   (hofs_w[hs_r]),
      .busy    (home_busy),
      .done    (hpair_done),
      .srch_m  (srch_m),
      .srch_s  (srch_s),
      .go      (hgo),
      .tgt_m   (tgt_m),
      .tgt_s   (tgt_s)
   );

   assign home_done = hpair_done;

   for (genvar a = 0; a < NAX; a++) begin : g_hm
      wire logic is_m = hm_r == 2'(a);
      wire logic is_s = hs_r == 2'(a);
      assign home_search[a] = (is_m & srch_m) | (is_s & srch_s);
      assign home_go[a]     = (is_m | is_s) & hgo;
      assign home_tgt[a]    = is_m ? tgt_m : is_s ? tgt_s : 16'h0000;
   end

   // ---------------- checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_PLANE_SLOT: assert property ((pl_ready[3] || pl_ready[2]) |-> act_npl_r == 3'h4)
      else $error("inactive plane offered a slot");
   AST_INIT_ONLY: assert property (!$stable(act_map_r) || !$stable(act_gan_r) |->
      $past(init_r) && act_map_r == $past(map_r))
      else $error("live configuration changed without init");
   AST_FB_ERR: assert property (ce && fb_err_c |=> fb_err_r && status_w[0])
      else $error("plane conflict not reported");

   for (genvar a = 0; a < NAX; a++) begin : g_ast
      AST_BLOCKED: assert property (ce && blocked[a] |=> !axis_cmd[a].valid)
         else $error("blocked axis received motion");
      AST_SLAVE_EN: assert property (ce && mst_v[a] && en_sw[mst_i[a]] |=> drv_en[a])
         else $error("slave not enabled with its master");
      AST_MIRROR: assert property (ce && linked[a] && !blocked[a] &&
         !blocked[mst_i[a]] && hit[mst_i[a]] |=> axis_cmd[a].valid &&
         axis_cmd[$past(mst_i[a])].valid &&
         axis_cmd[a].step == ($past(inv[a]) ? apg_step_t'(-axis_cmd[$past(mst_i[a])].step)
                                            : axis_cmd[$past(mst_i[a])].step))
         else $error("master command not mirrored to slave");
   end
endmodule // apg_map_gantry

// ---- pkg/apg_pkg.sv ----
// apg_pkg: register offsets, field layout, reset values and carriers
// assumes one 10 MHz controller clock and a 32-bit Avalon-MM register bus
package apg_pkg;
   localparam int          NAX         = 4;
   localparam int          NPL         = 4;
   localparam int          CLK_HZ      = 10_000_000;
   localparam int          BUF_BYTES   = 8192;
   localparam logic [4:0]  OFS_MAP     = 5'h00;
   localparam logic [4:0]  OFS_GANTRY  = 5'h04;
   localparam logic [4:0]  OFS_CTRL    = 5'h08;
   localparam logic [4:0]  OFS_STATUS  = 5'h0C;
   localparam logic [4:0]  OFS_HOFS_A  = 5'h10;
   localparam logic [4:0]  OFS_HOFS_B  = 5'h14;
   localparam logic [4:0]  OFS_HFEED   = 5'h18;
   localparam logic [4:0]  OFS_ACTMAP  = 5'h1C;
   // one byte per axis in map and gantry words
   localparam int          MAP_PL_LSB  = 0;
   localparam int          MAP_DS_LSB  = 3;
   localparam int          GAN_YES     = 0;
   localparam int          GAN_SL_LSB  = 1;
   localparam int          GAN_INV     = 3;
   localparam int          CTL_INIT    = 0;
   localparam int          CTL_HOME    = 1;
   localparam int          CTL_HAX_LSB = 2;
   localparam int          CTL_EN_LSB  = 4;
   localparam int          CTL_NPL_LSB = 8;
   localparam logic [31:0] MAP_RST     = 32'h1911_0901;
   localparam logic [31:0] GAN_RST     = 32'h0000_0000;
   localparam logic [31:0] CTL_RST     = 32'h0000_0100;
   localparam logic [31:0] HOFS_RST    = 32'h0000_0000;
   localparam logic [31:0] HFEED_RST   = 32'h0A0A_0A0A;
   localparam logic [2:0]  NPL_RST     = 3'h1;

   typedef enum logic [1:0] {DES_X, DES_Y, DES_Z, DES_U} apg_des_t;
   typedef logic signed [15:0] apg_step_t;
   typedef struct packed {
      logic      valid;
      apg_des_t  des;
      apg_step_t step;
   } apg_pcmd_t;
   typedef struct packed {
      logic      valid;
      apg_step_t step;
   } apg_acmd_t;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [4:0]  address;
      logic [3:0]  byteenable;
      logic [31:0] writedata;
   } apg_avs_req_t;

   function automatic logic [2:0] apg_plane(input logic [31:0] w, input int a);
      return w[8*a+MAP_PL_LSB +: 3];
   endfunction
   function automatic apg_des_t apg_desf(input logic [31:0] w, input int a);
      return apg_des_t'(w[8*a+MAP_DS_LSB +: 2]);
   endfunction
   function automatic logic [1:0] apg_gslv(input logic [31:0] w, input int a);
      return w[8*a+GAN_SL_LSB +: 2];
   endfunction
   function automatic logic [31:0] apg_merge(input logic [31:0] o,
                                             input logic [31:0] w,
                                             input logic [3:0]  be);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = w[8*i +: 8];
         end
      end
      return r;
   endfunction
endpackage

// ---- rtl/apg_cfg_chk.sv ----
// apg_cfg_chk: decodes the latched gantry and map words into slave links
// assumes words already latched; purely combinational
`timescale 1ns/10ps
module apg_cfg_chk (
   input  wire logic [31:0]      map_w,
   input  wire logic [31:0]      gan_w,
   output logic [3:0]            mst_v,
   output logic [3:0][1:0]       mst_i,
   output logic [3:0]            inv,
   output logic [3:0]            blocked,
   output logic                  fb_err,
   output logic                  role_err
);
   import apg_pkg::*;

   always_comb begin
      logic [1:0] s;
      s        = 2'h0;
      mst_v    = 4'h0;
      mst_i    = '0;
      inv      = 4'h0;
      role_err = 1'b0;
      fb_err   = 1'b0;
      for (int m = 0; m < NAX; m++) begin
         if (gan_w[8*m+GAN_YES]) begin
            s = apg_gslv(gan_w, m);
            // self-slaving or two masters on one slave cannot be linked
            if (s == 2'(m) || mst_v[s]) begin
               role_err = 1'b1;
            end else begin
               mst_v[s] = 1'b1;
               mst_i[s] = 2'(m);
               inv[s]   = gan_w[8*m+GAN_INV];
            end
         end
      end
      for (int a = 0; a < NAX; a++) begin
         blocked[a] = apg_plane(map_w, a) == 3'h0 || apg_plane(map_w, a) > 3'h4;
         if (gan_w[8*a+GAN_YES] && mst_v[a]) begin
            role_err = 1'b1;
         end
         // slave mapped into a plane other than its master's: two plane owners
         if (mst_v[a] && !blocked[a] &&
             apg_plane(map_w, a) != apg_plane(map_w, int'(mst_i[a]))) begin
            fb_err = 1'b1;
         end
      end
   end
endmodule // apg_cfg_chk

// ---- rtl/apg_home_pair.sv ----
// apg_home_pair: coordinated home cycle of one gantry master/slave pair
// assumes marker inputs already synchronised, move-done pulses on this clock
`timescale 1ns/10ps
module apg_home_pair (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic              ce,
   input  wire logic              start,
   input  wire logic              mk_m,
   input  wire logic              mk_s,
   input  wire logic              dn_m,
   input  wire logic              dn_s,
   input  wire apg_pkg::apg_step_t dist_m,
   input  wire apg_pkg::apg_step_t dist_s,
   input  wire apg_pkg::apg_step_t ofs_m,
   input  wire apg_pkg::apg_step_t ofs_s,
   output logic                   busy,
   output logic                   done,
   output logic                   srch_m,
   output logic                   srch_s,
   output logic                   go,
   output apg_pkg::apg_step_t     tgt_m,
   output apg_pkg::apg_step_t     tgt_s
);
   import apg_pkg::*;

   typedef enum logic [1:0] {HS_IDLE, HS_SRCH, HS_MOVE} apg_hst_t;

   apg_hst_t st_r, st_nxt;
   logic     fm_r, fs_r, fm_nxt, fs_nxt, go_nxt, done_nxt;

   always_comb begin
      st_nxt   = st_r;
      fm_nxt   = fm_r;
      fs_nxt   = fs_r;
      go_nxt   = 1'b0;
      done_nxt = 1'b0;
      case (st_r)
         HS_IDLE: begin
            if (start) begin
               st_nxt = HS_SRCH;
               fm_nxt = 1'b0;
               fs_nxt = 1'b0;
            end
         end
         HS_SRCH: begin
            fm_nxt = fm_r | mk_m;
            fs_nxt = fs_r | mk_s;
            if (fm_nxt && fs_nxt) begin
               st_nxt = HS_MOVE;
               go_nxt = 1'b1;
               fm_nxt = 1'b0;
               fs_nxt = 1'b0;
            end
         end
         HS_MOVE: begin
            fm_nxt = fm_r | dn_m;
            fs_nxt = fs_r | dn_s;
            if (fm_nxt && fs_nxt) begin
               st_nxt   = HS_IDLE;
               done_nxt = 1'b1;
            end
         end
         default: st_nxt = HS_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= HS_IDLE;
         fm_r <= 1'b0;
         fs_r <= 1'b0;
         go   <= 1'b0;
         done <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         fm_r <= fm_nxt;
         fs_r <= fs_nxt;
         go   <= go_nxt;
         done <= done_nxt;
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         tgt_m <= 16'h0000;
         tgt_s <= 16'h0000;
      end else if (ce && go_nxt) begin
         tgt_m <= apg_step_t'(dist_m + ofs_m);
         tgt_s <= apg_step_t'(dist_s + ofs_s);
      end
   end

   // an axis that found its marker stops searching and waits for its partner
   assign busy   = st_r != HS_IDLE;
   assign srch_m = st_r == HS_SRCH && !fm_r;
   assign srch_s = st_r == HS_SRCH && !fs_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_GO_BOTH_MARKERS: assert property ($rose(go) |->
      $past(fm_r || mk_m) && $past(fs_r || mk_s) && st_r == HS_MOVE)
      else $error("home move issued before both markers were found");
   AST_DONE_BOTH_MOVES: assert property ($rose(done) |->
      $past(fm_r || dn_m) && $past(fs_r || dn_s) && st_r == HS_IDLE)
      else $error("home done before both axes finished");
   AST_TARGET_SUM: assert property ($rose(go) |->
      tgt_m == $past(dist_m + ofs_m) && tgt_s == $past(dist_s + ofs_s))
      else $error("home target is not distance plus offset");
endmodule // apg_home_pair

// ---- test/apg_drive_model.sv ----
// apg_drive_model: marker sources and home moves of all axes
// assumes home_search and home_go come from the block on ref_clk
`timescale 1ns/10ps
module apg_drive_model (
   input  wire logic                ref_clk,
   input  wire logic [3:0]          home_search,
   input  wire logic [3:0]          home_go,
   output logic [3:0]               marker_pin,
   output logic [3:0]               mv_done,
   output apg_pkg::apg_step_t [3:0] null_dist,
   output logic [2:0]               moves_done
);
   import apg_pkg::*;
   int srch_c [4];
   int mv_c [4];
   initial begin
      marker_pin = '0;
      mv_done = '0;
      moves_done = '0;
      for (int i = 0; i < 4; i++) begin
         null_dist[i] = apg_step_t'(100 + i);
         srch_c[i] = 0;
         mv_c[i] = 0;
      end
   end
   // axes find markers and finish moves at different times, so one must wait
   always @(posedge ref_clk) begin
      for (int i = 0; i < 4; i++) begin
         srch_c[i] <= home_search[i] ? srch_c[i] + 1 : 0;
         marker_pin[i] <= home_search[i] && (srch_c[i] > 2 + 6 * i);
         mv_c[i] <= home_go[i] ? 3 + 6 * i : (mv_c[i] != 0 ? mv_c[i] - 1 : 0);
         mv_done[i] <= (mv_c[i] == 1);
         if (mv_c[i] == 1) begin
            moves_done <= moves_done + 3'h1;
         end
      end
   end
endmodule // apg_drive_model

// ---- test/axis_plane_map_gantry_link_tb.sv ----
// axis_plane_map_gantry_link_tb: self-checking bench of the map and gantry block
// assumes apg_drive_model on the far side; ce held high throughout
`timescale 1ns/10ps
module axis_plane_map_gantry_link_tb;
   import apg_pkg::*;
   logic               ref_clk, reset_n, ce, wreq, h_busy, h_done;
   apg_avs_req_t       req;
   logic [31:0]        rdata, rd;
   apg_pcmd_t [3:0]    pl_cmd;
   logic [3:0]         pl_ready, drv_en, marker_pin, mv_done, h_srch, h_go;
   apg_acmd_t [3:0]    axis_cmd;
   apg_step_t [3:0]    null_dist, h_tgt;
   logic [3:0][7:0]    h_feed;
   logic [2:0]         moves_done;
   int                 failures = 0, check_count = 0, cyc = 0;
   apg_map_gantry dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .ce(ce), .avs_req(req),
      .avs_readdata(rdata), .avs_waitrequest(wreq), .pl_cmd(pl_cmd), .pl_ready(pl_ready),
      .axis_cmd(axis_cmd), .drv_en(drv_en), .marker_pin(marker_pin), .mv_done(mv_done),
      .null_dist(null_dist), .home_search(h_srch), .home_go(h_go), .home_tgt(h_tgt),
      .home_feed(h_feed), .home_busy(h_busy), .home_done(h_done));
   apg_drive_model far_u (.ref_clk(ref_clk), .home_search(h_srch), .home_go(h_go),
      .marker_pin(marker_pin), .mv_done(mv_done), .null_dist(null_dist),
      .moves_done(moves_done));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   task automatic tally_and_finish;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   // holds the request until waitrequest is seen low at a rising edge
   task automatic bus(logic wr, logic [4:0] a, logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      req <= '{read: !wr, write: wr, address: a, byteenable: 4'hF, writedata: d};
      do @(posedge ref_clk); while (wreq !== 1'b0);
      q = rdata;
      req <= '0;
   endtask
   task automatic cfg(logic [31:0] m, logic [31:0] g, logic [31:0] c);
      bus(1'b1, OFS_MAP, m, rd);
      bus(1'b1, OFS_GANTRY, g, rd);
      bus(1'b1, OFS_CTRL, c, rd);
      repeat (4) @(posedge ref_clk);
   endtask
   task automatic send(int p, apg_des_t d, apg_step_t s);
      @(posedge ref_clk);
      pl_cmd[p] <= '{valid: 1'b1, des: d, step: s};
      do @(posedge ref_clk); while (pl_ready[p] !== 1'b1);
      pl_cmd[p] <= '0;
      @(negedge ref_clk);
   endtask
   task automatic t_defaults;
      bus(1'b0, OFS_MAP, 32'h0, rd);
      chk("map", MAP_RST, rd);
      bus(1'b0, OFS_GANTRY, 32'h0, rd);
      chk("gantry", GAN_RST, rd);
      bus(1'b0, 5'h02, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
   endtask
   task automatic t_route;
      send(0, DES_X, 16'sh0005);
      chk("ax0", 32'h0001_0005, 32'(axis_cmd[0]));
      chk("ax1 idle", 32'h0, 32'(axis_cmd[1].valid));
      send(0, DES_U, -16'sh0003);
      chk("ax3", 32'h0001_FFFD, 32'(axis_cmd[3]));
   endtask
   task automatic t_block;
      cfg(32'h1911_0A00, 32'h0, 32'h0000_0401);
      send(0, DES_X, 16'sh0005);
      chk("blocked ax0", 32'h0, 32'(axis_cmd[0].valid));
      send(1, DES_Y, 16'sh0009);
      chk("plane2 ax1", 32'h0001_0009, 32'(axis_cmd[1]));
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status 4 planes", 32'h0800_0100, rd);
   endtask
   task automatic t_gantry;
      cfg(32'h1911_0A01, 32'h0000_000B, 32'h0000_0211);
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("fb err", 32'h1, 32'(rd[0]));
      chk("drv_en", 32'h3, 32'(drv_en));
      bus(1'b1, OFS_GANTRY, 32'h0, rd);
      send(0, DES_X, 16'sh0005);
      chk("master", 32'h0001_0005, 32'(axis_cmd[0]));
      chk("slave inv", 32'h0001_FFFB, 32'(axis_cmd[1]));
   endtask
   task automatic t_home;
      bus(1'b1, OFS_HOFS_A, 32'h0000_0007, rd);
      bus(1'b1, OFS_CTRL, 32'h0000_0112, rd);
      for (int i = 0; i < 300 && h_go[0] !== 1'b1; i++) @(negedge ref_clk);
      chk("go", 32'h3, 32'(h_go));
      chk("search", 32'h0, 32'(h_srch[1:0]));
      chk("tgt0", 32'h6B, 32'(h_tgt[0]));
      chk("tgt1", 32'h65, 32'(h_tgt[1]));
      chk("feed", 32'h0A, 32'(h_feed[1]));
      chk("busy", 32'h1, 32'(h_busy));
      send(0, DES_X, 16'sh0003);
      chk("unlinked slave", 32'h0, 32'(axis_cmd[1].valid));
      for (int i = 0; i < 300 && h_done !== 1'b1; i++) @(negedge ref_clk);
      chk("done", 32'h1, 32'(h_done));
      chk("moves", 32'h2, 32'(moves_done));
      bus(1'b0, OFS_STATUS, 32'h0, rd);
      chk("status home", 32'h1000_0039, rd);
   endtask
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         tally_and_finish;
      end
   end
   initial begin
      reset_n = 1'b0;
      ce = 1'b1;
      req = '0;
      pl_cmd = '0;
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      t_defaults;
      t_route;
      t_block;
      t_gantry;
      t_home;
      tally_and_finish;
   end
endmodule // axis_plane_map_gantry_link_tb
